// ==== core/htor_regs.sv ====
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "htor_consts.svh"
// Summary of operation
// - Positive sustain offset: signed byte, reset zero
// - Non-overdrive positive drive is positive sustain
// - Positive adjust equals offset times step period
// - Negative sustain offset: signed byte, reset zero
// - Non-braking negative drive is negative sustain
// - Negative adjust equals offset times step period
// - Brake offset: signed byte, reset zero
// - Most negative drive marks the braking segment
// - Brake offset acts in open loop only
// - Brake adjust equals offset times step period
// - Peak window code selects 10/20/30/40 ms
// - Corner code selects 100/125/150/200 Hz
// - Samples below input floor are ignored
// - Floor volts equal code times 1.8/255
module htor_regs
  import htor_pkg::*;
#(
  parameter int CYCLES_PER_MS = `HTOR_MS_NS / `HTOR_CLK_PERIOD_NS
)(
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Segment request from the playback engine
  input wire logic segValid,
  input wire logic signed [7:0] segDrive,
  input wire logic signed [7:0] segPeak,
  input wire logic signed [7:0] segTrough,
  input wire logic [15:0] segNominalMs,
  // Segment answer
  output logic segOutValid,
  output logic [1:0] segOutClass,
  output logic signed [11:0] segOutAdjMs,
  output logic [15:0] segOutDurMs,
  // Settings seen by the engine
  output logic [7:0] sustainPosOffset,
  output logic [7:0] sustainNegOffset,
  output logic [7:0] brakeOffset,
  output logic stepPeriodSelect,
  output logic closedLoop,
  // Audio-to-vibe path
  input wire logic a2vSampleValid,
  input wire logic [7:0] a2vSampleLevel,
  output logic a2vPeakValid,
  output logic [7:0] a2vPeakLevel,
  output logic [5:0] a2vPeakWindowMs,
  output logic [7:0] a2vLowpassCornerHz,
  output logic [7:0] a2vInputFloor,
  output logic [10:0] a2vInputFloorMv
);
  // ==========================================================
  // Register storage
  logic [7:0] posOff_q; // Positive sustain offset
  logic [7:0] negOff_q; // Negative sustain offset
  logic [7:0] brkOff_q; // Brake offset
  logic [3:0] a2vCtrl_q; // Peak window and corner codes
  logic [7:0] floor_q; // Minimum input level
  logic [1:0] cfg_q; // Step period select and loop mode

  // ==========================================================
  // APB decode
  logic [7:0] regIdx; // Word index of the access
  logic mapped; // Address hits a register
  logic accessPhase; // Second cycle of a transfer
  logic wrStrobe; // Write takes effect this edge

  assign regIdx = paddr[9:2];
  assign accessPhase = psel && penable;
  assign wrStrobe = accessPhase && pwrite && mapped;

  // Address decode; only aligned words in the low window hit
  always_comb begin
    if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (regIdx == `HTOR_IDX_POS || regIdx == `HTOR_IDX_NEG) begin
      mapped = 1'b1;
    end else if (regIdx == `HTOR_IDX_BRK || regIdx == `HTOR_IDX_A2V) begin
      mapped = 1'b1;
    end else if (regIdx == `HTOR_IDX_FLR || regIdx == `HTOR_IDX_CFG) begin
      mapped = 1'b1;
    end else if (regIdx == `HTOR_IDX_STS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // No wait states; an unmapped address answers with an error
  assign pready = 1'b1;
  assign pslverr = accessPhase && !mapped;

  // ==========================================================
  // Register writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      posOff_q <= `HTOR_RST_POS;
      negOff_q <= `HTOR_RST_NEG;
      brkOff_q <= `HTOR_RST_BRK;
      a2vCtrl_q <= `HTOR_RST_A2V;
      floor_q <= `HTOR_RST_FLR;
      cfg_q <= `HTOR_RST_CFG;
    end else if (wrStrobe) begin
      if (regIdx == `HTOR_IDX_POS) begin
        posOff_q <= pwdata[7:0];
      end else if (regIdx == `HTOR_IDX_NEG) begin
        negOff_q <= pwdata[7:0];
      end else if (regIdx == `HTOR_IDX_BRK) begin
        brkOff_q <= pwdata[7:0];
      end else if (regIdx == `HTOR_IDX_A2V) begin
        // Reserved upper nibble is dropped here
        a2vCtrl_q <= pwdata[3:0];
      end else if (regIdx == `HTOR_IDX_FLR) begin
        floor_q <= pwdata[7:0];
      end else if (regIdx == `HTOR_IDX_CFG) begin
        cfg_q <= pwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Read data, captured in the setup cycle so it is stable
  // from a flip-flop throughout the access cycle
  logic [1:0] lastClass_q; // Class of the last segment
  logic [7:0] lastPeak_q; // Last peak reported
  logic [31:0] rdMux; // Read value for the current index

  always_comb begin
    rdMux = 32'h00000000;
    if (regIdx == `HTOR_IDX_POS) begin
      rdMux = {24'h000000, posOff_q};
    end else if (regIdx == `HTOR_IDX_NEG) begin
      rdMux = {24'h000000, negOff_q};
    end else if (regIdx == `HTOR_IDX_BRK) begin
      rdMux = {24'h000000, brkOff_q};
    end else if (regIdx == `HTOR_IDX_A2V) begin
      rdMux = {28'h0000000, a2vCtrl_q};
    end else if (regIdx == `HTOR_IDX_FLR) begin
      rdMux = {24'h000000, floor_q};
    end else if (regIdx == `HTOR_IDX_CFG) begin
      rdMux = {30'h00000000, cfg_q};
    end else if (regIdx == `HTOR_IDX_STS) begin
      rdMux = {16'h0000, lastPeak_q, 6'h00, lastClass_q};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      // Unmapped reads return zero with the error flag
      prdata <= mapped ? rdMux : 32'h00000000;
    end
  end

  // Settings straight from storage
  assign sustainPosOffset = posOff_q;
  assign sustainNegOffset = negOff_q;
  assign brakeOffset = brkOff_q;
  assign stepPeriodSelect = cfg_q[`HTOR_CFG_STEP_BIT];
  assign closedLoop = cfg_q[`HTOR_CFG_CLOSED_BIT];
  assign a2vInputFloor = floor_q;

  // ==========================================================
  // Segment classification and offset
  logic [3:0] stepMs; // Current step period in ms
  htor_seg_t segClass_d; // Class of the incoming value
  logic signed [11:0] segAdj_d; // Signed adjustment in ms
  htor_seg_t segClass_q; // Registered class
  logic signed [11:0] segAdj_q; // Registered adjustment
  logic [15:0] segNom_q; // Registered nominal length
  logic segStage_q; // Request held in stage one

  assign stepMs = stepPeriodSelect ? `HTOR_STEP_FAST_MS : `HTOR_STEP_SLOW_MS;

  // Overdrive (the peak value) is left alone; its offset lives
  // elsewhere. The brake test precedes the generic negative one.
  always_comb begin
    segClass_d = HTOR_SEG_OTHER;
    segAdj_d = 12'sh000;
    if (segDrive > 8'sh00 && segDrive == segPeak) begin
      segClass_d = HTOR_SEG_OTHER;
    end else if (segDrive > 8'sh00) begin
      segClass_d = HTOR_SEG_POS;
      segAdj_d = $signed({{4{posOff_q[7]}}, posOff_q})
               * $signed({8'h00, stepMs});
    end else if (segDrive < 8'sh00 && segDrive == segTrough) begin
      segClass_d = HTOR_SEG_BRAKE;
      if (!closedLoop) begin
        segAdj_d = $signed({{4{brkOff_q[7]}}, brkOff_q})
                 * $signed({8'h00, stepMs});
      end else begin
        // Closed loop brakes on its own; offset unused
        segAdj_d = 12'sh000;
      end
    end else if (segDrive < 8'sh00) begin
      segClass_d = HTOR_SEG_NEG;
      segAdj_d = $signed({{4{negOff_q[7]}}, negOff_q})
               * $signed({8'h00, stepMs});
    end
  end

  // Stage one: class and adjustment
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      segStage_q <= 1'b0;
      segClass_q <= HTOR_SEG_OTHER;
      segAdj_q <= 12'sh000;
      segNom_q <= 16'h0000;
    end else begin
      segStage_q <= segValid;
      if (segValid) begin
        segClass_q <= segClass_d;
        segAdj_q <= segAdj_d;
        segNom_q <= segNominalMs;
      end
    end
  end

  // Stage two: class and adjustment registered on the same edge as the clamped length
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      segOutClass <= 2'h0;
      segOutAdjMs <= 12'sh000;
      lastClass_q <= 2'h0;
    end else if (segStage_q) begin
      segOutClass <= segClass_q;
      segOutAdjMs <= segAdj_q;
      lastClass_q <= segClass_q;
    end
  end

  // Duration clamp
  htor_seg_clamp u_clamp (
    .clock(clock),
    .nrst(nrst),
    .inValid(segStage_q),
    .nominalMs(segNom_q),
    .adjMs(segAdj_q),
    .outValid(segOutValid),
    .durMs(segOutDurMs)
  );

  // ==========================================================
  // Audio-to-vibe settings decode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      a2vPeakWindowMs <= 6'h00;
      a2vLowpassCornerHz <= 8'h00;
      a2vInputFloorMv <= 11'h000;
    end else begin
      // Window is ten ms per code step, code zero meaning ten
      a2vPeakWindowMs <= 6'(`HTOR_PEAK_STEP_MS
        * ({4'h0, a2vCtrl_q[`HTOR_A2V_PEAK_HI:`HTOR_A2V_PEAK_LO]} + 6'h01));
      case (a2vCtrl_q[`HTOR_A2V_FILT_HI:`HTOR_A2V_FILT_LO])
        2'h0: a2vLowpassCornerHz <= `HTOR_CORNER_0_HZ;
        2'h1: a2vLowpassCornerHz <= `HTOR_CORNER_1_HZ;
        2'h2: a2vLowpassCornerHz <= `HTOR_CORNER_2_HZ;
        default: a2vLowpassCornerHz <= `HTOR_CORNER_3_HZ;
      endcase
      // Floor in millivolts, truncated toward zero
      a2vInputFloorMv <= 11'(({12'h000, floor_q} * `HTOR_FLOOR_FS_MV)
        / `HTOR_FLOOR_FS_CODE);
    end
  end

  // ==========================================================
  // Millisecond enable from the system clock
  logic [31:0] msCnt_q; // Cycle counter within one ms
  logic msTick; // One-cycle pulse per ms

  assign msTick = (msCnt_q == 32'(CYCLES_PER_MS - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      msCnt_q <= 32'h00000000;
    end else if (msTick) begin
      msCnt_q <= 32'h00000000;
    end else begin
      msCnt_q <= msCnt_q + 32'h00000001;
    end
  end

  // ==========================================================
  // Peak detection over the selected window
  logic [5:0] winMs_q; // Elapsed ms in this window
  logic [7:0] peak_q; // Running peak this window
  logic winEnd; // Window closes this cycle
  logic sampleOk; // Sample at or above the floor
  logic [7:0] peakCand; // Peak including this cycle's sample

  assign winEnd = msTick && (winMs_q + 6'h01 >= a2vPeakWindowMs);
  assign sampleOk = a2vSampleValid && (a2vSampleLevel >= floor_q);
  assign peakCand = (sampleOk && a2vSampleLevel > peak_q) ? a2vSampleLevel : peak_q;

  // A sample landing on the closing edge still counts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      winMs_q <= 6'h00;
      peak_q <= 8'h00;
      a2vPeakValid <= 1'b0;
      a2vPeakLevel <= 8'h00;
      lastPeak_q <= 8'h00;
    end else begin
      a2vPeakValid <= winEnd;
      if (winEnd) begin
        winMs_q <= 6'h00;
        peak_q <= 8'h00;
        a2vPeakLevel <= peakCand;
        lastPeak_q <= peakCand;
      end else begin
        if (msTick) begin
          winMs_q <= winMs_q + 6'h01;
        end
        peak_q <= peakCand;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence sqWrite(logic [7:0] idx);
    psel && penable && pwrite && paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0
      && paddr[9:2] == idx;
  endsequence

  sequence sqPosSeg;
    segValid && segDrive > 8'sh00 && segDrive != segPeak;
  endsequence

  AST_POS_WRITE: assert property (
    sqWrite(`HTOR_IDX_POS) |=> sustainPosOffset == $past(pwdata[7:0]))
    else $error("positive offset write lost");

  AST_POS_CLASS: assert property (
    sqPosSeg |=> segClass_q == HTOR_SEG_POS ##1 segOutClass == HTOR_SEG_POS)
    else $error("positive sustain not classified");

  AST_POS_ADJ: assert property (
    (sqPosSeg and !$changed(posOff_q)) |=> ##1
      segOutAdjMs == $signed({{4{$past(posOff_q[7], 2)}}, $past(posOff_q, 2)})
        * $signed({8'h00, $past(stepMs, 2)}))
    else $error("positive adjustment wrong");

  AST_NEG_CLASS: assert property (
    segValid && segDrive < 8'sh00 && segDrive != segTrough
      |=> segClass_q == HTOR_SEG_NEG)
    else $error("negative sustain not classified");

  AST_BRAKE_OPEN: assert property (
    segValid && segDrive < 8'sh00 && segDrive == segTrough && !closedLoop
      |=> segClass_q == HTOR_SEG_BRAKE
        && segAdj_q == $signed({{4{$past(brkOff_q[7])}}, $past(brkOff_q)})
           * $signed({8'h00, $past(stepMs)}))
    else $error("open loop brake adjustment wrong");

  AST_BRAKE_CLOSED: assert property (
    segValid && segDrive < 8'sh00 && segDrive == segTrough && closedLoop
      |=> ##1 segOutClass == HTOR_SEG_BRAKE && segOutAdjMs == 12'sh000)
    else $error("brake offset applied in closed loop");

  AST_RSVD_ZERO: assert property (
    psel && !penable && !pwrite && paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0
      && paddr[9:2] == `HTOR_IDX_A2V |=> prdata[31:4] == 28'h0000000)
    else $error("reserved control bits read nonzero");

  AST_PEAK_WINDOW: assert property (
    sqWrite(`HTOR_IDX_A2V) ##1 !wrStrobe |=> a2vPeakWindowMs
      == 6'(`HTOR_PEAK_STEP_MS * ({4'h0, $past(pwdata[3:2], 2)} + 6'h01)))
    else $error("peak window decode wrong");

  AST_FLOOR_IGNORE: assert property (
    a2vSampleValid && a2vSampleLevel < floor_q && !winEnd |=> $stable(peak_q))
    else $error("sample below floor was used");

  AST_PEAK_PULSE: assert property (
    winEnd |=> a2vPeakValid ##1 !a2vPeakValid [*2])
    else $error("peak valid not one cycle");
endmodule : htor_regs

// ==== core/htor_consts.svh ====
`ifndef HTOR_CONSTS_SVH
`define HTOR_CONSTS_SVH
// ==========================================================
// Register indices (byte address is the index shifted left)
`define HTOR_IDX_POS 8'h0e
`define HTOR_IDX_NEG 8'h0f
`define HTOR_IDX_BRK 8'h10
`define HTOR_IDX_A2V 8'h11
`define HTOR_IDX_FLR 8'h12
`define HTOR_IDX_CFG 8'h20
`define HTOR_IDX_STS 8'h21
// ==========================================================
// Reset values
`define HTOR_RST_POS 8'h00
`define HTOR_RST_NEG 8'h00
`define HTOR_RST_BRK 8'h00
`define HTOR_RST_A2V 4'h5
`define HTOR_RST_FLR 8'h19
`define HTOR_RST_CFG 2'h0
// ==========================================================
// Field positions
`define HTOR_A2V_PEAK_HI 3
`define HTOR_A2V_PEAK_LO 2
`define HTOR_A2V_FILT_HI 1
`define HTOR_A2V_FILT_LO 0
`define HTOR_CFG_STEP_BIT 0
`define HTOR_CFG_CLOSED_BIT 1
// ==========================================================
// Timing and scaling
`define HTOR_CLK_PERIOD_NS 8
`define HTOR_MS_NS 1000000
`define HTOR_STEP_SLOW_MS 4'h5
`define HTOR_STEP_FAST_MS 4'h1
`define HTOR_PEAK_STEP_MS 6'h0a
`define HTOR_CORNER_0_HZ 8'h64
`define HTOR_CORNER_1_HZ 8'h7d
`define HTOR_CORNER_2_HZ 8'h96
`define HTOR_CORNER_3_HZ 8'hc8
`define HTOR_FLOOR_FS_MV 20'h00708
`define HTOR_FLOOR_FS_CODE 20'h000ff
`endif

// ==== core/htor_pkg.sv ====
package htor_pkg;
  // ==========================================================
  // Segment classes seen by the playback engine
  typedef enum logic [1:0] {
    HTOR_SEG_OTHER = 2'b00, // Overdrive or zero drive, no offset here
    HTOR_SEG_POS   = 2'b01, // Positive sustain
    HTOR_SEG_NEG   = 2'b10, // Negative sustain
    HTOR_SEG_BRAKE = 2'b11  // Most negative portion
  } htor_seg_t;
endpackage : htor_pkg

// ==== core/htor_seg_clamp.sv ====
`timescale 1ns/1ps
`include "htor_consts.svh"
module htor_seg_clamp
  import htor_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  input wire logic [15:0] nominalMs,
  input wire logic signed [11:0] adjMs,
  output logic outValid,
  output logic [15:0] durMs
);
  // ==========================================================
  // Adjusted duration, widened so neither end can wrap
  logic signed [17:0] sumMs; // Nominal plus signed adjustment
  logic [15:0] durMs_d; // Clamped next duration

  always_comb begin
    sumMs = $signed({2'b00, nominalMs}) + $signed({{6{adjMs[11]}}, adjMs});
    if (sumMs < 18'sh00000) begin
      // Negative offset longer than segment: stop at zero
      durMs_d = 16'h0000;
    end else if (sumMs > 18'sh0ffff) begin
      // Saturate rather than wrap on the long side too
      durMs_d = 16'hffff;
    end else begin
      durMs_d = sumMs[15:0];
    end
  end

  // Result register, one cycle behind the request
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      outValid <= 1'b0;
      durMs <= 16'h0000;
    end else begin
      outValid <= inValid;
      if (inValid) begin
        durMs <= durMs_d;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_CLAMP_ZERO: assert property (
    inValid && ($signed({2'b00, nominalMs}) + $signed({{6{adjMs[11]}}, adjMs}) < 18'sh00000)
    |=> outValid && (durMs == 16'h0000))
    else $error("negative sum not clamped to zero");

  AST_SUM_PASS: assert property (
    inValid && !adjMs[11] && ({1'b0, nominalMs} + {5'h00, adjMs} <= 17'h0ffff)
    |=> durMs == $past(nominalMs) + $past({4'h0, adjMs}))
    else $error("positive adjustment not added");
endmodule : htor_seg_clamp

// ==== tb/htor_regs_bench.sv ====
`timescale 1ns/1ps
`include "htor_consts.svh"
module htor_regs_bench
  import htor_pkg::*;
;
  // ==========================================================
  // Clock, reset and stimulus
  localparam int CPM = 4; // Short millisecond so windows last tens of cycles
  logic clock; // 125 MHz bench clock
  logic nrst; // Active low reset
  logic psel, penable, pwrite; // APB controls
  logic [11:0] paddr; // APB byte address
  logic [31:0] pwdata, prdata; // APB data
  logic pready, pslverr; // APB answer
  logic segValid; // Segment strobe
  logic signed [7:0] segDrive, segPeak, segTrough; // Segment drive values
  logic [15:0] segNominalMs; // Nominal segment length
  logic segOutValid; // Segment answer strobe
  logic [1:0] segOutClass; // Segment class
  logic signed [11:0] segOutAdjMs; // Applied adjustment
  logic [15:0] segOutDurMs; // Adjusted duration
  logic [7:0] sustainPosOffset, sustainNegOffset, brakeOffset; // Offset outputs
  logic stepPeriodSelect, closedLoop; // Mode outputs
  logic a2vSampleValid, a2vPeakValid; // Audio path strobes
  logic [7:0] a2vSampleLevel, a2vPeakLevel, a2vLowpassCornerHz, a2vInputFloor; // Audio data
  logic [5:0] a2vPeakWindowMs; // Peak window in ms
  logic [10:0] a2vInputFloorMv; // Floor in millivolts
  int badCount = 0; // Mismatches seen
  int comparisons = 0; // Comparisons made

  htor_regs #(.CYCLES_PER_MS(CPM)) htor_regs_inst (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .segValid(segValid), .segDrive(segDrive), .segPeak(segPeak), .segTrough(segTrough),
    .segNominalMs(segNominalMs), .segOutValid(segOutValid), .segOutClass(segOutClass),
    .segOutAdjMs(segOutAdjMs), .segOutDurMs(segOutDurMs),
    .sustainPosOffset(sustainPosOffset), .sustainNegOffset(sustainNegOffset),
    .brakeOffset(brakeOffset), .stepPeriodSelect(stepPeriodSelect), .closedLoop(closedLoop),
    .a2vSampleValid(a2vSampleValid), .a2vSampleLevel(a2vSampleLevel),
    .a2vPeakValid(a2vPeakValid), .a2vPeakLevel(a2vPeakLevel),
    .a2vPeakWindowMs(a2vPeakWindowMs), .a2vLowpassCornerHz(a2vLowpassCornerHz),
    .a2vInputFloor(a2vInputFloor), .a2vInputFloorMv(a2vInputFloorMv)
  );

  // Free running clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Ends the run; also reached by the watchdog
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err, input logic [1:0] low = 2'h0);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, low};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
    check("write error", {31'h0, err}, 32'h0);
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0, rd, err);
    check(what, rd, exp);
    check("read error", {31'h0, err}, 32'h0);
  endtask : rdChk

  // Present one segment (peak 50, trough -50, 30 ms) and judge the answer
  task automatic seg(input logic signed [7:0] drv, input logic [1:0] cls, input int adj,
                     input int dur);
    @(posedge clock);
    segValid <= 1'b1;
    segDrive <= drv;
    @(posedge clock);
    segValid <= 1'b0;
    // Outputs are looked at mid-cycle, where they have settled
    for (int i = 0; i < 6; i++) begin
      @(negedge clock);
      if (segOutValid === 1'b1) break;
    end
    check("segment strobe", {31'h0, segOutValid}, 32'h1);
    check("segment class", {30'h0, segOutClass}, {30'h0, cls});
    check("segment adjust", 32'(segOutAdjMs), adj);
    check("segment duration", {16'h0, segOutDurMs}, dur);
  endtask : seg

  task automatic sample(input logic [7:0] lvl);
    @(posedge clock);
    a2vSampleValid <= 1'b1;
    a2vSampleLevel <= lvl;
    @(posedge clock);
    a2vSampleValid <= 1'b0;
  endtask : sample

  // Waits for the end of a peak window, bounded
  task automatic waitPeak();
    for (int i = 0; i < 400; i++) begin
      @(negedge clock);
      if (a2vPeakValid === 1'b1) return;
    end
    check("peak strobe", 32'h0, 32'h1);
  endtask : waitPeak

  // ==========================================================
  // Scenarios
  task automatic resetValues();
    logic [31:0] rd;
    logic err;
    rdChk("pos offset reset", `HTOR_IDX_POS, 32'h0);
    rdChk("neg offset reset", `HTOR_IDX_NEG, 32'h0);
    rdChk("brake offset reset", `HTOR_IDX_BRK, 32'h0);
    rdChk("a2v control reset", `HTOR_IDX_A2V, 32'h05);
    rdChk("floor reset", `HTOR_IDX_FLR, 32'h19);
    check("window reset", {26'h0, a2vPeakWindowMs}, 32'd20);
    check("corner reset", {24'h0, a2vLowpassCornerHz}, 32'd125);
    check("floor mv reset", {21'h0, a2vInputFloorMv}, 32'd176);
    apb(1'b0, `HTOR_IDX_POS, 32'h0, rd, err, 2'h1);
    check("misaligned error", {31'h0, err}, 32'h1);
  endtask : resetValues

  // Every peak window and corner code, reserved bits written as ones
  task automatic a2vCodes();
    int corner [4] = '{100, 125, 150, 200};
    for (int c = 0; c < 4; c++) begin
      wr(`HTOR_IDX_A2V, 32'hf0 | (c * 5));
      rdChk("a2v control", `HTOR_IDX_A2V, c * 5);
      repeat (3) @(posedge clock);
      check("peak window", {26'h0, a2vPeakWindowMs}, (c + 1) * 10);
      check("corner", {24'h0, a2vLowpassCornerHz}, corner[c]);
    end
    wr(`HTOR_IDX_FLR, 32'h80);
    repeat (3) @(posedge clock);
    check("floor mv", {21'h0, a2vInputFloorMv}, 32'd903);
    check("floor out", {24'h0, a2vInputFloor}, 32'h80);
  endtask : a2vCodes

  task automatic segments();
    wr(`HTOR_IDX_POS, 32'hfe);
    wr(`HTOR_IDX_NEG, 32'h03);
    wr(`HTOR_IDX_BRK, 32'h04);
    check("pos offset out", {24'h0, sustainPosOffset}, 32'hfe);
    seg(8'sd10, HTOR_SEG_POS, -10, 20);
    check("neg offset out", {24'h0, sustainNegOffset}, 32'h03);
    check("brake offset out", {24'h0, brakeOffset}, 32'h04);
    seg(8'sd50, HTOR_SEG_OTHER, 0, 30);
    seg(8'sd0, HTOR_SEG_OTHER, 0, 30);
    seg(-8'sd10, HTOR_SEG_NEG, 15, 45);
    seg(-8'sd50, HTOR_SEG_BRAKE, 20, 50);
    wr(`HTOR_IDX_POS, 32'h80);
    seg(8'sd10, HTOR_SEG_POS, -640, 0);
    wr(`HTOR_IDX_CFG, 32'h1);
    seg(-8'sd10, HTOR_SEG_NEG, 3, 33);
    check("step select out", {31'h0, stepPeriodSelect}, 32'h1);
    wr(`HTOR_IDX_CFG, 32'h3);
    seg(-8'sd50, HTOR_SEG_BRAKE, 0, 30);
    check("closed loop out", {31'h0, closedLoop}, 32'h1);
  endtask : segments

  // Below-floor samples never reach the peak, a sample at the floor does
  task automatic floorGate();
    wr(`HTOR_IDX_A2V, 32'h01);
    wr(`HTOR_IDX_FLR, 32'h40);
    waitPeak();
    sample(8'h30);
    sample(8'h50);
    sample(8'h3f);
    waitPeak();
    check("peak level", {24'h0, a2vPeakLevel}, 32'h50);
    sample(8'h3f);
    waitPeak();
    check("peak below floor", {24'h0, a2vPeakLevel}, 32'h0);
    sample(8'h40);
    waitPeak();
    check("peak at floor", {24'h0, a2vPeakLevel}, 32'h40);
    // Status holds the last peak and the class of the last (brake) segment
    rdChk("status", `HTOR_IDX_STS, 32'h00004003);
  endtask : floorGate

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, segValid, a2vSampleValid} = '0;
    paddr = '0;
    pwdata = '0;
    segDrive = '0;
    segPeak = 8'sd50;
    segTrough = -8'sd50;
    segNominalMs = 16'd30;
    a2vSampleLevel = '0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    resetValues();
    a2vCodes();
    segments();
    floorGate();
    conclude();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(8 * 20000);
    badCount++;
    conclude();
  end
endmodule : htor_regs_bench
